// file: src/dest_mask_pkg.sv
// constants, table layouts and carrier types for the destination port mask resolver
package dest_mask_pkg;
   localparam int PORTS = 11;
   localparam int GROUP_DEPTH = 139;
   localparam int SRC_DEPTH = 23;
   localparam int AGGR_DEPTH = 16;
   localparam int UNIT_DEPTH = 32;
   localparam int SVC_DEPTH = 16;
   localparam int VLAN_DEPTH = 16;
   localparam int GLOBAL_AGGREGATION_GROUP_GROUPS = 8;
   // group table layout
   localparam logic [7:0] FLOOD_BASE = 8'h0B;
   localparam logic [2:0] FLOOD_LAST = 3'h5;
   localparam logic [7:0] MC_OFFSET = 8'h0B;
   localparam logic [7:0] GLOBAL_AGGREGATION_GROUP_BASE = 8'h4B;
   localparam logic [4:0] SRC_GLOBAL_BASE = 5'h0F;
   // group entry fields
   localparam int GE_STACK = 11;
   localparam int GE_CPU_EN = 12;
   localparam int GE_QUEUE_LSB = 13;
   localparam int PAIR_PORT_LSB = 0;
   localparam int PAIR_UNIT_LSB = 4;
   // service entry fields
   localparam int SV_MASK_OVR = 11;
   localparam int SV_SRC_OFF = 12;
   localparam int SV_AGGR_OVR = 13;
   localparam int SV_AGGR_LSB = 14;
   localparam int SV_KIND_LSB = 18;
   localparam int SV_ADDR_LSB = 21;
   localparam logic [2:0] SVC_KIND_FLOOD = 3'h7;
   localparam logic [2:0] SVC_KIND_MC = 3'h3;
   // request forwarding decisions
   localparam logic [1:0] FWD_FLOOD = 2'h0;
   localparam logic [1:0] FWD_UNICAST = 2'h1;
   localparam logic [1:0] FWD_MULTICAST = 2'h2;
   localparam logic [2:0] MODE_REPLACE_GROUP = 3'h1;
   localparam logic [2:0] MODE_REDIRECT_GROUP = 3'h4;
   // flood classes and sticky flag positions
   localparam logic [2:0] FC_UC = 3'h0;
   localparam logic [2:0] FC_L2MC = 3'h1;
   localparam logic [2:0] FC_IP4_DATA = 3'h2;
   localparam logic [2:0] FC_IP4_CTRL = 3'h3;
   localparam logic [2:0] FC_IP6_DATA = 3'h4;
   localparam logic [2:0] FC_IP6_CTRL = 3'h5;
   localparam int ST_UC = 0;
   localparam int ST_L2MC = 1;
   localparam int ST_NO_FWD = 6;
   localparam int ST_CPU = 7;
   // register map, byte addresses
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_STICKY = 12'h004;
   localparam logic [11:0] A_STICKY_MASK = 12'h008;
   localparam logic [3:0] WIN_GROUP0 = 4'h4;
   localparam logic [3:0] WIN_GROUP1 = 4'h5;
   localparam logic [3:0] WIN_GROUP2 = 4'h6;
   localparam logic [3:0] WIN_SRC = 4'h8;
   localparam logic [3:0] WIN_AGGR = 4'h9;
   localparam logic [3:0] WIN_UNIT = 4'hA;
   localparam logic [3:0] WIN_SVC = 4'hB;
   localparam logic [3:0] WIN_VLAN = 4'hC;
   localparam logic [3:0] WIN_GLOBAL_AGGREGATION_GROUP = 4'hD;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   typedef struct packed {
      logic valid;
      logic [3:0] vlan_idx;
      logic service_fwd;
      logic [3:0] service_index;
      logic [1:0] fwd_kind;
      logic [2:0] flood_sel;
      logic [2:0] flood_class;
      logic [4:0] stack_unit_id;
      logic [3:0] stack_unit_port;
      logic [7:0] multicast_index;
      logic global_aggregation_group_dest;
      logic [2:0] global_aggregation_group_dest_id;
      logic [2:0] mask_mode;
      logic [10:0] port_mask;
      logic l2_fwd;
      logic [3:0] src_port;
      logic src_global_aggregation_group;
      logic [2:0] src_global_aggregation_group_id;
      logic routed;
      logic [3:0] aggregation_hash_code;
   } req_s;

   typedef struct packed {
      logic valid;
      logic discard;
      logic [10:0] dest_mask;
      logic cpu_copy;
      logic [2:0] cpu_queue;
   } res_s;
endpackage

// file: src/destination_port_mask_resolver.sv
// destination port mask resolver: tables, mask combination, sticky events, apb slave
// Contract
// R1: vlan mask limits egress to vlan ports
// R2: service mask applies, may replace vlan mask
// R3: flood uses group entries 11 to 16
// R4: local unit unicast uses entries 0-10
// R5: remote unit unicast uses unit table
// R6: multicast reads entry index plus 11
// R7: stack bit selects direct or unit resolution
// R8: replace mode uses request mask directly
// R9: cleared layer2 forward flag discards frame
// R10: entry cpu copy enable sends cpu copy
// R11: sticky flags, counted when mask bit set
// R12: source mask by ingress port, entries 0-14
// R13: global source mask, entries 15-22
// R14: redirect mode 4 skips source filtering
// R15: service source filter off skips filtering
// R16: routed frames skip source filtering
// R17: aggregation code indexes 16-entry mask table
// R18: unaggregated ports pass aggregation unchanged
// R19: service may override aggregation selection
// R20: exit calc uses entries 75-138, stacked
// R21: software programs member counts before use
// R22: service kind 7 floods, 3 multicasts
// R23: final mask ands all applicable masks
// R24: fixed two-cycle latency, sticky cleared
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module destination_port_mask_resolver
   import dest_mask_pkg::*;
(
   input wire logic pclk, // core and bus clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire req_s req, // classifier request
   output res_s res, // resolved destination
   output logic [7:0] stat_event // events forwarded to port statistics
);
   logic [15:0] group_tab [GROUP_DEPTH];
   logic [10:0] src_tab [SRC_DEPTH];
   logic [10:0] aggr_tab [AGGR_DEPTH];
   logic [10:0] unit_tab [UNIT_DEPTH];
   logic [28:0] svc_tab [SVC_DEPTH];
   logic [10:0] vlan_tab [VLAN_DEPTH];
   logic [3:0] global_aggregation_group_count [GLOBAL_AGGREGATION_GROUP_GROUPS];
   logic [31:0] ctrl;
   logic [7:0] sticky;
   logic [7:0] sticky_mask;
   req_s s1;
   logic global_group_exit_calc_en;
   logic [4:0] local_unit_id;

   logic [28:0] svc;
   logic [1:0] kind;
   logic [7:0] mc_addr;
   logic [8:0] mc_sum;
   logic [7:0] grp_addr;
   logic [15:0] entry;
   logic use_group;
   logic [10:0] group_mask;
   logic [10:0] base_mask;
   logic [10:0] src_mask;
   logic [10:0] gsrc_mask;
   logic [10:0] aggr_mask;
   logic [10:0] req_mask;
   logic [3:0] aggr_idx;
   logic [2:0] member;
   logic replace;
   logic src_filter;
   logic [7:0] events;
   res_s next_res;

   logic setup;
   logic wr;
   logic [31:0] next_prdata;
   logic next_err;

   assign global_group_exit_calc_en = ctrl[0];
   assign local_unit_id = ctrl[5:1];
   assign setup = psel && !penable;
   assign wr = psel && penable && pready && pwrite;

   function automatic logic [15:0] rd_group(input logic [7:0] a);
      if (a < 8'(GROUP_DEPTH)) begin
         rd_group = group_tab[a];
      end else begin
         rd_group = 16'h0000;
      end
   endfunction

   // stacked pair: own unit goes to front port entry, others to the unit table
   function automatic logic [10:0] resolve_pair(input logic [15:0] e, input logic [4:0] own);
      if (e[PAIR_UNIT_LSB +: 5] == own) begin
         resolve_pair = 11'(rd_group({4'h0, e[PAIR_PORT_LSB +: 4]})); // R4
      end else begin
         resolve_pair = unit_tab[e[PAIR_UNIT_LSB +: 5]]; // R5
      end
   endfunction

   // window decode: is the word address inside a table of given depth
   function automatic logic in_tab(input logic [11:0] a, input logic [3:0] win, input int depth);
      in_tab = (a[11:8] == win) && (int'(a[7:2]) < depth) && (a[1:0] == 2'b00);
   endfunction

   // request stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= '0;
      end else begin
         s1 <= req;
      end
   end

   // resolution stage
   always_comb begin
      svc = svc_tab[s1.service_index];
      kind = s1.fwd_kind;
      mc_addr = s1.multicast_index;
      if (s1.service_fwd) begin
         if (svc[SV_KIND_LSB +: 3] == SVC_KIND_FLOOD) begin
            kind = FWD_FLOOD; // R22
         end else if (svc[SV_KIND_LSB +: 3] == SVC_KIND_MC) begin
            kind = FWD_MULTICAST; // R22
            mc_addr = svc[SV_ADDR_LSB +: 8]; // R22
         end
      end
      member = 3'h0;
      if (global_aggregation_group_count[s1.global_aggregation_group_dest_id] != 4'h0) begin
         member = 3'(s1.aggregation_hash_code % global_aggregation_group_count[s1.global_aggregation_group_dest_id]);
      end
      // carry kept: an index past the table end must not wrap onto front ports
      mc_sum = {1'b0, mc_addr} + {1'b0, MC_OFFSET};
      use_group = 1'b1;
      grp_addr = 8'h00;
      if (global_group_exit_calc_en && s1.global_aggregation_group_dest) begin
         grp_addr = GLOBAL_AGGREGATION_GROUP_BASE + {2'b00, s1.global_aggregation_group_dest_id, 3'b000} + {5'b00000, member}; // R20
      end else begin
         case (kind)
            FWD_FLOOD: begin
               grp_addr = FLOOD_BASE + {5'b00000, (s1.flood_sel > FLOOD_LAST) ? FLOOD_LAST : s1.flood_sel}; // R3
            end
            FWD_UNICAST: begin
               if (s1.stack_unit_id == local_unit_id) begin
                  grp_addr = {4'h0, s1.stack_unit_port}; // R4
               end else begin
                  use_group = 1'b0; // R5
               end
            end
            FWD_MULTICAST: begin
               grp_addr = mc_sum[8] ? 8'hFF : mc_sum[7:0]; // R6
            end
            default: begin
               use_group = 1'b0;
            end
         endcase
      end
      entry = use_group ? rd_group(grp_addr) : 16'h0000;
      if (!use_group) begin
         group_mask = unit_tab[s1.stack_unit_id]; // R5
      end else if (entry[GE_STACK]) begin
         group_mask = resolve_pair(entry, local_unit_id); // R7 R20
      end else begin
         group_mask = entry[10:0]; // R7
      end
      replace = (s1.mask_mode == MODE_REPLACE_GROUP);
      req_mask = s1.port_mask;
      if (replace) begin
         group_mask = s1.port_mask; // R8
         req_mask = '1;
      end
      base_mask = vlan_tab[s1.vlan_idx]; // R1
      if (s1.service_fwd) begin
         if (svc[SV_MASK_OVR]) begin
            base_mask = svc[10:0]; // R2
         end else begin
            base_mask = base_mask & svc[10:0]; // R2
         end
      end
      src_filter = !(s1.mask_mode == MODE_REDIRECT_GROUP) // R14
         && !(s1.service_fwd && svc[SV_SRC_OFF]) // R15
         && !s1.routed; // R16
      src_mask = '1;
      gsrc_mask = '1;
      if (src_filter) begin
         if (int'(s1.src_port) < int'(SRC_GLOBAL_BASE)) begin
            src_mask = src_tab[s1.src_port]; // R12
         end
         if (s1.src_global_aggregation_group) begin
            gsrc_mask = src_tab[SRC_GLOBAL_BASE + {2'b00, s1.src_global_aggregation_group_id}]; // R13
         end
      end
      aggr_idx = s1.aggregation_hash_code; // R17
      if (s1.service_fwd && svc[SV_AGGR_OVR]) begin
         aggr_idx = svc[SV_AGGR_LSB +: 4]; // R19
      end
      aggr_mask = aggr_tab[aggr_idx]; // R17 R18
      next_res.valid = s1.valid;
      next_res.discard = !s1.l2_fwd; // R9
      next_res.dest_mask = s1.l2_fwd ? (base_mask & group_mask & src_mask & gsrc_mask & aggr_mask & req_mask) : '0; // R23
      next_res.cpu_copy = s1.l2_fwd && !replace && use_group && entry[GE_CPU_EN]; // R10
      next_res.cpu_queue = entry[GE_QUEUE_LSB +: 3]; // R10
      events = 8'h00;
      if (s1.valid) begin
         events[ST_CPU] = next_res.cpu_copy; // R11
         events[ST_NO_FWD] = !s1.l2_fwd; // R11
         if (s1.l2_fwd && !replace && kind == FWD_FLOOD && !(global_group_exit_calc_en && s1.global_aggregation_group_dest)) begin
            case (s1.flood_class)
               FC_UC: events[ST_UC] = 1'b1; // R11
               FC_L2MC: events[ST_L2MC] = 1'b1; // R11
               FC_IP4_DATA: events[2] = 1'b1; // R11
               FC_IP4_CTRL: events[3] = 1'b1; // R11
               FC_IP6_DATA: events[4] = 1'b1; // R11
               FC_IP6_CTRL: events[5] = 1'b1; // R11
               default: events = events;
            endcase
         end
      end
   end

   // result and statistics outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res <= '0;
         stat_event <= 8'h00;
      end else begin
         res <= next_res; // R24
         stat_event <= events & sticky_mask; // R11
      end
   end

   // sticky flags: hardware set wins over write-one-to-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sticky <= 8'h00; // R24
      end else begin
         if (wr && paddr == A_STICKY) begin
            sticky <= (sticky & ~pwdata[7:0]) | events; // R11
         end else begin
            sticky <= sticky | events; // R11
         end
      end
   end

   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
         sticky_mask <= 8'h00;
      end else if (wr) begin
         if (paddr == A_CTRL) begin
            ctrl <= {26'h0, pwdata[5:0]};
         end
         if (paddr == A_STICKY_MASK) begin
            sticky_mask <= pwdata[7:0];
         end
      end
   end

   // table writes; tables are not reset, software loads them before traffic
   always_ff @(posedge pclk) begin
      if (wr) begin
         if (in_tab(paddr, WIN_GROUP0, 64)) begin
            group_tab[{2'b00, paddr[7:2]}] <= pwdata[15:0];
         end
         if (in_tab(paddr, WIN_GROUP1, GROUP_DEPTH - 64)) begin
            group_tab[8'(paddr[7:2]) + 8'h40] <= pwdata[15:0];
         end
         if (in_tab(paddr, WIN_GROUP2, GROUP_DEPTH - 128)) begin
            group_tab[8'(paddr[7:2]) + 8'h80] <= pwdata[15:0]; // R20
         end
         if (in_tab(paddr, WIN_SRC, SRC_DEPTH)) begin
            src_tab[paddr[6:2]] <= pwdata[10:0];
         end
         if (in_tab(paddr, WIN_AGGR, AGGR_DEPTH)) begin
            aggr_tab[paddr[5:2]] <= pwdata[10:0];
         end
         if (in_tab(paddr, WIN_UNIT, UNIT_DEPTH)) begin
            unit_tab[paddr[6:2]] <= pwdata[10:0];
         end
         if (in_tab(paddr, WIN_SVC, SVC_DEPTH)) begin
            svc_tab[paddr[5:2]] <= pwdata[28:0];
         end
         if (in_tab(paddr, WIN_VLAN, VLAN_DEPTH)) begin
            vlan_tab[paddr[5:2]] <= pwdata[10:0];
         end
         if (in_tab(paddr, WIN_GLOBAL_AGGREGATION_GROUP, GLOBAL_AGGREGATION_GROUP_GROUPS)) begin
            global_aggregation_group_count[paddr[4:2]] <= pwdata[3:0]; // R21
         end
      end
   end

   // read mux, evaluated during the setup phase
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_err = 1'b0;
      if (paddr == A_CTRL) begin
         next_prdata = ctrl;
      end else if (paddr == A_STICKY) begin
         next_prdata = {24'h0, sticky};
      end else if (paddr == A_STICKY_MASK) begin
         next_prdata = {24'h0, sticky_mask};
      end else if (in_tab(paddr, WIN_GROUP0, 64)) begin
         next_prdata = {16'h0, group_tab[{2'b00, paddr[7:2]}]};
      end else if (in_tab(paddr, WIN_GROUP1, GROUP_DEPTH - 64)) begin
         next_prdata = {16'h0, group_tab[8'(paddr[7:2]) + 8'h40]};
      end else if (in_tab(paddr, WIN_GROUP2, GROUP_DEPTH - 128)) begin
         next_prdata = {16'h0, group_tab[8'(paddr[7:2]) + 8'h80]};
      end else if (in_tab(paddr, WIN_SRC, SRC_DEPTH)) begin
         next_prdata = {21'h0, src_tab[paddr[6:2]]};
      end else if (in_tab(paddr, WIN_AGGR, AGGR_DEPTH)) begin
         next_prdata = {21'h0, aggr_tab[paddr[5:2]]};
      end else if (in_tab(paddr, WIN_UNIT, UNIT_DEPTH)) begin
         next_prdata = {21'h0, unit_tab[paddr[6:2]]};
      end else if (in_tab(paddr, WIN_SVC, SVC_DEPTH)) begin
         next_prdata = {3'h0, svc_tab[paddr[5:2]]};
      end else if (in_tab(paddr, WIN_VLAN, VLAN_DEPTH)) begin
         next_prdata = {21'h0, vlan_tab[paddr[5:2]]};
      end else if (in_tab(paddr, WIN_GLOBAL_AGGREGATION_GROUP, GLOBAL_AGGREGATION_GROUP_GROUPS)) begin
         next_prdata = {28'h0, global_aggregation_group_count[paddr[4:2]]};
      end else begin
         next_err = 1'b1;
      end
   end

   // apb answer: ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         prdata <= (setup && !pwrite) ? next_prdata : 32'h0000_0000;
         pslverr <= setup && next_err;
      end
   end
endmodule

// file: tb/classifier_model.sv
// upstream classifier model: hands one request to the resolver per call
`timescale 1ns/1ps
module classifier_model
   import dest_mask_pkg::*;
(
   input wire logic pclk, // core clock
   output req_s req // request toward the resolver
);
   initial req = '0;
   task automatic send(input req_s r);
      req_s t;
      t = ~r;
      t.valid = 1'b0;
      @(posedge pclk);
      req <= r;
      @(posedge pclk);
      req <= t; // idle: fields inverted so stale values never look valid
   endtask
endmodule

// file: tb/dest_mask_chk.sv
// port checker for the destination port mask resolver
`timescale 1ns/1ps
module dest_mask_chk
   import dest_mask_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire req_s req, // request
   input wire res_s res, // result
   input wire logic [7:0] stat_event // statistics events
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_LATENCY: assert property (req.valid |-> ##2 res.valid) else $error("result missing");
   AST_NO_SPURIOUS: assert property (res.valid |-> $past(req.valid, 2)) else $error("result without request");
   AST_DISCARD: assert property (req.valid && !req.l2_fwd |-> ##2 res.discard && res.dest_mask == '0)
      else $error("frame not discarded");
   AST_REPLACE: assert property (req.valid && req.l2_fwd && req.mask_mode == MODE_REPLACE_GROUP |->
      ##2 (res.dest_mask & ~$past(req.port_mask, 2)) == '0) else $error("replace mask exceeded");
   AST_NOFWD_EVENT: assert property (stat_event[ST_NO_FWD] |-> res.valid && res.discard)
      else $error("no forward event wrong");
   AST_CPU_EVENT: assert property (stat_event[ST_CPU] |-> res.valid && res.cpu_copy) else $error("cpu event wrong");
   AST_EVENT_FRAME: assert property (stat_event != '0 |-> res.valid) else $error("event outside frame");
   AST_APB_READY: assert property (psel && !penable |=> pready ##1 !pready) else $error("apb ready timing");
   AST_APB_ERR: assert property (pslverr |-> pready && prdata == '0) else $error("apb error data");
   cover property (res.valid && res.cpu_copy);
   cover property (res.valid && res.discard);
   cover property (pslverr);
endmodule
bind destination_port_mask_resolver dest_mask_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .req(req), .res(res), .stat_event(stat_event));

// file: tb/tb.sv
// self-checking bench for the destination port mask resolver
`timescale 1ns/1ps
module tb;
   import dest_mask_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [7:0] stat_event, ev;
   req_s req, r;
   res_s res, got;
   int err_count = 0, samples_checked = 0, cycles = 0;
   always #5 pclk = ~pclk;
   classifier_model u_src (.pclk(pclk), .req(req));
   destination_port_mask_resolver u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req(req), .res(res), .stat_event(stat_event));
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         $display("unexpected at %0t: run timed out", $time);
         test_done();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask
   function automatic logic [11:0] ga(input int i);
      return i < 64 ? 12'h400 + 12'(4 * i) : 12'h500 + 12'(4 * (i - 64));
   endfunction
   function automatic req_s base();
      req_s q;
      q = '0;
      q.valid = 1'b1;
      q.l2_fwd = 1'b1;
      q.src_port = 4'hF;
      q.port_mask = 11'h7FF;
      return q;
   endfunction
   task automatic frame(input logic [10:0] m, input logic d);
      u_src.send(r);
      @(posedge pclk);
      #1;
      got = res;
      ev = stat_event;
      chk(32'(got.valid), 32'h1, "valid");
      chk(32'(got.dest_mask), 32'(m), "mask");
      chk(32'(got.discard), 32'(d), "discard");
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdc(A_CTRL, CTRL_RESET, "ctrl reset");
      rdc(A_STICKY, 32'h0, "sticky reset");
      rdc(12'hF00, 32'h0, "unmapped data");
      chk(32'(er), 32'h1, "unmapped error");
      wr(A_CTRL, 32'h6);
      wr(A_STICKY_MASK, 32'hFF);
      wr(12'hC00, 32'h7FF);
      wr(12'hC04, 32'h00F);
      for (int i = 0; i < 23; i++) wr(12'h800 + 12'(4 * i), i < 11 ? 32'h7FF & ~(32'h1 << i) : 32'h7FF);
      wr(12'h844, 32'h7F3);
      for (int i = 0; i < 16; i++) wr(12'h900 + 12'(4 * i), i == 5 ? 32'h7FE : i == 6 ? 32'h7FD : 32'h7FF);
      for (int i = 0; i < 17; i++) wr(ga(i), i < 11 ? 32'h1 << i : 32'h7FF >> (i - 11));
      wr(ga(71), 32'hB0F0);
      wr(ga(72), 32'h871);
      wr(ga(83), 32'h870);
      wr(ga(84), 32'h834);
      wr(12'hA1C, 32'h300);
      wr(12'hB04, 32'h1C17FF);
      wr(12'hB08, 32'h1C08FF);
      wr(12'hB0C, 32'h1C00FF);
      wr(12'hB10, 32'h78C07FF);
      wr(12'hB14, 32'h1DA7FF);
      wr(12'hD04, 32'h2);
      for (int k = 0; k < 6; k++) begin
         r = base();
         r.flood_sel = 3'(k);
         r.flood_class = 3'(k);
         frame(11'h7FF >> k, 1'b0);
         chk(32'(ev), 32'h1 << k, "flood event");
      end
      r.flood_sel = 3'h7;
      frame(11'h03F, 1'b0);
      $display("test flood done");
      r = base();
      r.fwd_kind = FWD_UNICAST;
      r.stack_unit_id = 5'h03;
      r.stack_unit_port = 4'h5;
      r.src_port = 4'h2;
      frame(11'h020, 1'b0);
      r.stack_unit_id = 5'h07;
      frame(11'h300, 1'b0);
      r = base();
      r.fwd_kind = FWD_MULTICAST;
      r.multicast_index = 8'h3C;
      frame(11'h0F0, 1'b0);
      chk(32'({got.cpu_copy, got.cpu_queue}), 32'hD, "cpu copy");
      chk(32'(ev), 32'h80, "cpu event");
      r.multicast_index = 8'h3D;
      frame(11'h300, 1'b0);
      r.multicast_index = 8'hF5;
      frame(11'h000, 1'b0);
      r = base();
      r.mask_mode = MODE_REPLACE_GROUP;
      r.port_mask = 11'h555;
      r.flood_sel = 3'h5;
      frame(11'h555, 1'b0);
      r = base();
      r.l2_fwd = 1'b0;
      frame(11'h000, 1'b1);
      chk(32'(ev), 32'h40, "no forward event");
      $display("test lookup done");
      for (int v = 0; v < 4; v++) begin
         r = base();
         r.src_port = 4'h3;
         r.routed = (v == 1);
         r.mask_mode = v == 2 ? MODE_REDIRECT_GROUP : 3'h0;
         r.service_fwd = (v == 3);
         r.service_index = 4'h1;
         frame(v == 0 ? 11'h7F7 : 11'h7FF, 1'b0);
      end
      r = base();
      r.src_global_aggregation_group = 1'b1;
      r.src_global_aggregation_group_id = 3'h2;
      frame(11'h7F3, 1'b0);
      $display("test source done");
      r = base();
      r.vlan_idx = 4'h1;
      frame(11'h00F, 1'b0);
      r.service_fwd = 1'b1;
      r.service_index = 4'h2;
      frame(11'h0FF, 1'b0);
      r.service_index = 4'h3;
      frame(11'h00F, 1'b0);
      r = base();
      r.service_fwd = 1'b1;
      r.service_index = 4'h4;
      frame(11'h0F0, 1'b0);
      r.service_index = 4'h5;
      frame(11'h7FD, 1'b0);
      r = base();
      r.aggregation_hash_code = 4'h5;
      frame(11'h7FE, 1'b0);
      $display("test service done");
      wr(A_CTRL, 32'h7);
      r.global_aggregation_group_dest = 1'b1;
      r.global_aggregation_group_dest_id = 3'h1;
      frame(11'h010, 1'b0);
      r.aggregation_hash_code = 4'h4;
      frame(11'h300, 1'b0);
      $display("test exit done");
      rdc(A_STICKY, 32'hFF, "sticky set");
      wr(A_STICKY, 32'hFF);
      rdc(A_STICKY, 32'h0, "sticky clear");
      wr(A_STICKY_MASK, 32'h0);
      r = base();
      r.l2_fwd = 1'b0;
      frame(11'h000, 1'b1);
      chk(32'(ev), 32'h0, "masked event");
      rdc(A_STICKY, 32'h40, "sticky masked");
      rdc(ga(71), 32'hB0F0, "group readback");
      wr(ga(138), 32'h0877);
      rdc(ga(138), 32'h0877, "group top entry");
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdc(A_STICKY, 32'h0, "sticky after reset");
      rdc(A_CTRL, CTRL_RESET, "ctrl after reset");
      $display("test sticky done");
      test_done();
   end
endmodule
